// ===== rtl/tss_pkg.sv
// Package for the touch scan sequencer: map, fields, resets, timing
package tss_pkg;
  // Clock and timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int PHASE_OVH_NS = 1250;
  localparam int PRESS_OVH_NS = 1000;
  localparam int CONV_OVH_NS = 4400;
  localparam logic [11:0] PHASE_OVH_CYC =
    12'((PHASE_OVH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] PRESS_OVH_CYC =
    12'((PRESS_OVH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] CONV_OVH_CYC =
    12'((CONV_OVH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // Selectable settle, precharge and sense times, in ns
  localparam int SETTLE_NS [4] = '{100, 1000, 10000, 100000};
  localparam int PRE_NS [4] = '{500, 1000, 4000, 10000};
  localparam int SENSE_NS [4] = '{500, 1000, 4000, 10000};
  // Register offsets (word addresses)
  localparam logic [4:0] ADDR_X = 5'h00;
  localparam logic [4:0] ADDR_Y = 5'h01;
  localparam logic [4:0] ADDR_Z1 = 5'h02;
  localparam logic [4:0] ADDR_Z2 = 5'h03;
  localparam logic [4:0] ADDR_KEY = 5'h04;
  localparam logic [4:0] ADDR_DAC = 5'h0B;
  localparam logic [4:0] ADDR_CFG = 5'h0C;
  localparam logic [4:0] ADDR_CTL = 5'h0D;
  // Reset values
  localparam logic [15:0] RESULT_RST = 16'h0000;
  localparam logic [15:0] KEY_RST = 16'h0000;
  localparam logic [15:0] DAC_RST = 16'h0080;
  localparam logic [15:0] CFG_RST = 16'h0000;
  // Configuration fields
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_PRESS_BIT = 2;
  localparam int CFG_AVG_LSB = 3;
  localparam int CFG_RES_LSB = 5;
  localparam int CFG_SETTLE_LSB = 7;
  localparam int CFG_PRE_LSB = 9;
  localparam int CFG_SENSE_LSB = 11;
  localparam int CFG_DIV_LSB = 13;
  // Control fields
  localparam int CTL_START_BIT = 0;
  localparam int CTL_COORD_LSB = 1;
  localparam int CTL_BUSY_BIT = 15;
  localparam int CTL_READY_BIT = 14;
  localparam int ADC_BITS = 12;
  localparam int DAC_BITS = 8;
  // Unread flag positions (X, Y, Z1, Z2, keypad)
  localparam int UNREAD_KEY = 4;

  typedef enum logic [1:0] {
    TSS_MODE_SELF = 2'b00,
    TSS_MODE_HOST_INIT = 2'b01,
    TSS_MODE_HOST_CTRL = 2'b10
  } tss_mode_t;

  typedef enum logic [1:0] {
    TSS_COORD_X = 2'b00,
    TSS_COORD_Y = 2'b01,
    TSS_COORD_Z1 = 2'b10,
    TSS_COORD_Z2 = 2'b11
  } tss_coord_t;

  typedef enum logic [2:0] {
    TSS_IDLE = 3'b000,
    TSS_SETTLE = 3'b001,
    TSS_CONV = 3'b011,
    TSS_STORE = 3'b010,
    TSS_DONE = 3'b110
  } tss_state_t;

  // Rounded-up cycles for a time in ns
  function automatic logic [11:0] tss_cyc(input int ns);
    tss_cyc = 12'((ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  endfunction
endpackage

// ===== rtl/tss_scan_regs.sv
// Touch scan sequencer with result, keypad and current DAC registers
//
// Behaviour
// [RULE1] Reset clears results and keypad data; DAC register loads midscale.
// [RULE2] Results stored right-justified; unused upper bits read zero.
// [RULE3] Keypad data holds one bit per key, key n at bit n.
// [RULE4] DAC code sits in bits 7..0; bits 15..8 reserved, read zero.
// [RULE5] Three modes: touch-started, host-initiated, host-controlled.
// [RULE6] On touch, pen interrupt goes low and conversion clock powers up.
// [RULE7] Drive Y, settle, convert with averaging, store Y result.
// [RULE8] If still touched, repeat settle/convert/average for X, store X.
// [RULE9] X/Y scan: 2.5us plus two settle phases plus two conversions.
// [RULE10] With pressure enabled, measure and store two pressure values.
// [RULE11] Full scan: 4.75us, three settle phases, four conversions.
// [RULE12] Scan time grows with every timing field; no averaging means one.
// [RULE13] Host configures once, reads results after ready falls.
// [RULE14] Ready line idles high, drops on new data, rises when read.
// [RULE15] Matrix keys map row-major, column 1 lowest bit of row.
// [RULE16] Panel released before X conversion ends the scan; the code checks release only in touch-started mode, once, at the Y store.
`timescale 1ns/1ps
module tss_scan_regs
  import tss_pkg::*;
#(
  parameter int KEYS = 16
)
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [4:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  input wire logic panel_touched,
  input wire logic [tss_pkg::ADC_BITS-1:0] adc_data,
  input wire logic [KEYS-1:0] key_matrix,
  input wire logic key_valid,
  output logic pen_touch_irq_n,
  output logic result_ready_n,
  output logic conv_clk_en,
  output logic adc_power_on,
  output logic adc_sample,
  output logic y_drv_en,
  output logic x_drv_en,
  output logic z_drv_en,
  output logic [tss_pkg::DAC_BITS-1:0] dac_code_bits
);
  import tss_pkg::*;

  tss_state_t state_ff;
  tss_coord_t coord_ff;
  logic [11:0] cnt_ff;
  logic [2:0] avg_left_ff;
  logic [14:0] acc_ff;
  logic [15:0] res_ff [4];
  logic [15:0] key_bits_ff;
  logic [15:0] dac_ff;
  logic [15:0] cfg_ff;
  logic [1:0] single_coord_ff;
  logic start_ff;
  logic [4:0] unread_ff;
  logic [15:0] rdata_ff;
  logic pen_ff;
  logic sample_ff;
  logic [3:0] res_bits;
  logic [2:0] avg_shift;
  logic [11:0] settle_cyc;
  logic [11:0] conv_cyc;
  logic [14:0] avg_val;
  logic [15:0] result_bits;
  logic [15:0] key_bits;
  logic [4:0] unread_set;
  logic [4:0] unread_clr;
  tss_mode_t mode;
  logic wr_ctl;
  logic trigger;

  // Decoded configuration fields
  assign mode = tss_mode_t'(cfg_ff[CFG_MODE_LSB +: 2]);
  assign avg_shift = {1'b0, cfg_ff[CFG_AVG_LSB +: 2]};
  assign wr_ctl = reg_wr && (reg_addr == ADDR_CTL);

  // Resolution select: 12, 8, 10, 12 bits
  always_comb
  begin
    unique case (cfg_ff[CFG_RES_LSB +: 2])
      2'b01: res_bits = 4'h8;
      2'b10: res_bits = 4'hA;
      default: res_bits = 4'hC;
    endcase
  end

  // [RULE12] Timing grows with fields
  always_comb
  begin
    settle_cyc = tss_cyc(SETTLE_NS[cfg_ff[CFG_SETTLE_LSB +: 2]])
      + tss_cyc(PRE_NS[cfg_ff[CFG_PRE_LSB +: 2]])
      + tss_cyc(SENSE_NS[cfg_ff[CFG_SENSE_LSB +: 2]])
      + PHASE_OVH_CYC;
    // [RULE11] Pressure phase extra overhead
    if (coord_ff == TSS_COORD_Z1)
      settle_cyc = settle_cyc + PRESS_OVH_CYC;
    // Bit time is two, four, eight or sixteen ref clocks; the shift
    // amount is widened so the slowest setting does not wrap to zero
    conv_cyc = 12'({8'h00, res_bits}
      << ({1'b0, cfg_ff[CFG_DIV_LSB +: 2]} + 3'd1))
      + CONV_OVH_CYC;
  end

  // [RULE2] Average, then right-justify
  always_comb
  begin
    avg_val = acc_ff >> avg_shift;
    result_bits = 16'(avg_val[11:0] >> (4'hC - res_bits));
  end

  // [RULE15] Row-major key placement
  always_comb
  begin
    key_bits = '0;
    for (int r = 0; r < 4; r++)
      for (int c = 0; c < 4; c++)
        key_bits[r * 4 + c] = key_matrix[r * 4 + c];
  end

  // [RULE5] Scan start per mode
  always_comb
  begin
    unique case (mode)
      TSS_MODE_SELF: trigger = panel_touched;
      default: trigger = start_ff;
    endcase
  end

  // Host start request, held until the sequencer takes it
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      start_ff <= 1'b0;
    else if (wr_ctl && reg_wdata[CTL_START_BIT])
      start_ff <= 1'b1;
    else if (state_ff == TSS_IDLE)
      start_ff <= 1'b0;
  end

  // Configuration, control and DAC registers
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cfg_ff <= CFG_RST;
      // [RULE1] DAC resets to midscale
      dac_ff <= DAC_RST;
      single_coord_ff <= 2'b00;
    end
    else if (reg_wr)
    begin
      if (reg_addr == ADDR_CFG)
        cfg_ff <= reg_wdata;
      // [RULE4] Only low eight bits kept
      if (reg_addr == ADDR_DAC)
        dac_ff <= {8'h00, reg_wdata[7:0]};
      if (reg_addr == ADDR_CTL)
        single_coord_ff <= reg_wdata[CTL_COORD_LSB +: 2];
    end
  end

  // Scan sequencer
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_ff <= TSS_IDLE;
      coord_ff <= TSS_COORD_Y;
      cnt_ff <= 12'h000;
      avg_left_ff <= 3'h0;
      acc_ff <= 15'h0000;
      sample_ff <= 1'b0;
    end
    else
    begin
      sample_ff <= 1'b0;
      unique case (state_ff)
        TSS_IDLE:
          if (trigger)
          begin
            state_ff <= TSS_SETTLE;
            cnt_ff <= 12'h000;
            // [RULE7] Y first unless host picks one
            coord_ff <= (mode == TSS_MODE_HOST_CTRL)
              ? tss_coord_t'(single_coord_ff) : TSS_COORD_Y;
          end
        TSS_SETTLE:
          if (cnt_ff + 12'h001 >= settle_cyc)
          begin
            state_ff <= TSS_CONV;
            cnt_ff <= 12'h000;
            acc_ff <= 15'h0000;
            avg_left_ff <= 3'((4'h1 << avg_shift) - 4'h1);
            sample_ff <= 1'b1;
          end
          else
            cnt_ff <= cnt_ff + 12'h001;
        TSS_CONV:
          // [RULE9] Each conversion takes bits plus overhead
          if (cnt_ff + 12'h001 >= conv_cyc)
          begin
            acc_ff <= acc_ff + {3'b000, adc_data};
            cnt_ff <= 12'h000;
            if (avg_left_ff == 3'h0)
              state_ff <= TSS_STORE;
            else
            begin
              avg_left_ff <= avg_left_ff - 3'h1;
              sample_ff <= 1'b1;
            end
          end
          else
            cnt_ff <= cnt_ff + 12'h001;
        TSS_STORE:
        begin
          cnt_ff <= 12'h000;
          if (mode == TSS_MODE_HOST_CTRL)
            state_ff <= TSS_DONE;
          else if (coord_ff == TSS_COORD_Y)
          begin
            // [RULE16] Released panel ends scan
            if (!panel_touched && mode == TSS_MODE_SELF)
              state_ff <= TSS_DONE;
            else
            begin
              // [RULE8] Move on to X
              coord_ff <= TSS_COORD_X;
              state_ff <= TSS_SETTLE;
            end
          end
          else if (coord_ff == TSS_COORD_X && cfg_ff[CFG_PRESS_BIT])
          begin
            // [RULE10] Pressure pair follows X
            coord_ff <= TSS_COORD_Z1;
            state_ff <= TSS_SETTLE;
          end
          else if (coord_ff == TSS_COORD_Z1)
          begin
            // Second pressure value shares the Z1 settling
            coord_ff <= TSS_COORD_Z2;
            state_ff <= TSS_CONV;
            acc_ff <= 15'h0000;
            avg_left_ff <= 3'((4'h1 << avg_shift) - 4'h1);
            sample_ff <= 1'b1;
          end
          else
            state_ff <= TSS_DONE;
        end
        TSS_DONE:
          // Self mode waits for release so one touch gives one scan
          if (mode != TSS_MODE_SELF || !panel_touched)
            state_ff <= TSS_IDLE;
        default:
          state_ff <= TSS_IDLE;
      endcase
    end
  end

  // Result and keypad registers
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      // [RULE1] Results and keys clear
      for (int i = 0; i < 4; i++)
        res_ff[i] <= RESULT_RST;
      key_bits_ff <= KEY_RST;
    end
    else
    begin
      if (state_ff == TSS_STORE)
        res_ff[coord_ff] <= result_bits;
      // [RULE3] One bit per key
      if (key_valid)
        key_bits_ff <= key_bits;
    end
  end

  // Unread tracking; a new store beats a same-cycle read
  always_comb
  begin
    unread_set = '0;
    unread_clr = '0;
    if (state_ff == TSS_STORE)
      unread_set[coord_ff] = 1'b1;
    if (key_valid)
      unread_set[UNREAD_KEY] = 1'b1;
    if (reg_rd && reg_addr <= ADDR_KEY)
      unread_clr[reg_addr[2:0]] = 1'b1;
  end

  // [RULE14] Ready low while data unread
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      unread_ff <= '0;
    else
      unread_ff <= (unread_ff & ~unread_clr) | unread_set;
  end

  // Read data, registered one cycle after the strobe
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      rdata_ff <= 16'h0000;
    else if (reg_rd)
    begin
      unique case (reg_addr)
        ADDR_X, ADDR_Y, ADDR_Z1, ADDR_Z2: rdata_ff <= res_ff[reg_addr[1:0]];
        ADDR_KEY: rdata_ff <= key_bits_ff;
        ADDR_DAC: rdata_ff <= dac_ff;
        ADDR_CFG: rdata_ff <= cfg_ff;
        ADDR_CTL:
        begin
          rdata_ff <= {14'h0000, single_coord_ff} << CTL_COORD_LSB;
          rdata_ff[CTL_BUSY_BIT] <= (state_ff != TSS_IDLE);
          rdata_ff[CTL_READY_BIT] <= ~|unread_ff;
        end
        default: rdata_ff <= 16'h0000;
      endcase
    end
  end

  // [RULE6] Pen interrupt on touch
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      pen_ff <= 1'b0;
    else
      pen_ff <= panel_touched;
  end

  // Outputs; drivers follow the coordinate under measurement
  assign reg_rdata = rdata_ff;
  assign pen_touch_irq_n = ~pen_ff;
  assign result_ready_n = ~|unread_ff;
  assign conv_clk_en = (state_ff != TSS_IDLE);
  assign adc_power_on = (state_ff == TSS_CONV);
  assign adc_sample = sample_ff;
  assign y_drv_en = (state_ff == TSS_SETTLE || state_ff == TSS_CONV)
    && coord_ff == TSS_COORD_Y;
  assign x_drv_en = (state_ff == TSS_SETTLE || state_ff == TSS_CONV)
    && coord_ff == TSS_COORD_X;
  assign z_drv_en = (state_ff == TSS_SETTLE || state_ff == TSS_CONV)
    && (coord_ff == TSS_COORD_Z1 || coord_ff == TSS_COORD_Z2);
  assign dac_code_bits = dac_ff[7:0];
endmodule

// ===== tb/tb_top.sv
// Self-checking bench for the touch scan sequencer registers
`timescale 1ns/1ps
`define CHK(a, e) \
  begin \
    samples_checked++; \
    if ((a) !== (e)) \
    begin \
      n_errors++; \
      $display("unexpected at %0t got %h exp %h", $time, a, e); \
    end \
  end
`define WAIT_FOR(c) \
  begin \
    for (wait_i = 0; wait_i < 4000 && !(c); wait_i++) \
      @(posedge ref_clk); \
    `CHK(c, 1'b1) \
  end
module tb_top;
  import tss_pkg::*;
  localparam logic [11:0] VY = 12'h5A3;
  localparam logic [11:0] VX = 12'hA5C;
  localparam logic [11:0] VZ1 = 12'h3C1;
  localparam logic [11:0] VZ2 = 12'hC3E;
  localparam int SET0 = (SETTLE_NS[0] + PRE_NS[0] + SENSE_NS[0] + 39) / 40;
  localparam int SET1 = (SETTLE_NS[1] + PRE_NS[1] + SENSE_NS[1] + 39) / 40;
  localparam int OVH = (PHASE_OVH_NS + 39) / 40;
  localparam int CV0 = 12 * 2 + (CONV_OVH_NS + 39) / 40;
  localparam int CV1 = 12 * 4 + (CONV_OVH_NS + 39) / 40;
  localparam int CV3 = 8 * 16 + (CONV_OVH_NS + 39) / 40;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_wdata = 16'h0000;
  logic panel_touched = 1'b0;
  logic [15:0] key_matrix = 16'h0000;
  logic key_valid = 1'b0;
  logic [15:0] reg_rdata;
  logic [11:0] adc_data;
  logic [7:0] dac_code_bits;
  logic pen_touch_irq_n, result_ready_n, conv_clk_en, adc_power_on;
  logic adc_sample, y_drv_en, x_drv_en, z_drv_en;
  logic x_seen = 1'b0;
  int n_errors = 0;
  int samples_checked = 0;
  int wait_i;
  int width;

  tss_scan_regs uut (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .panel_touched(panel_touched),
    .adc_data(adc_data),
    .key_matrix(key_matrix),
    .key_valid(key_valid),
    .pen_touch_irq_n(pen_touch_irq_n),
    .result_ready_n(result_ready_n),
    .conv_clk_en(conv_clk_en),
    .adc_power_on(adc_power_on),
    .adc_sample(adc_sample),
    .y_drv_en(y_drv_en),
    .x_drv_en(x_drv_en),
    .z_drv_en(z_drv_en),
    .dac_code_bits(dac_code_bits)
  );
  tss_panel_model u_panel (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .adc_sample(adc_sample),
    .adc_power_on(adc_power_on),
    .y_drv_en(y_drv_en),
    .x_drv_en(x_drv_en),
    .z_drv_en(z_drv_en),
    .adc_data(adc_data)
  );

  // Free-running 25 MHz clock
  initial
    forever #20 ref_clk = ~ref_clk;

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
  endtask

  // Touch, time the X phase, read every result after ready falls
  // Results are right-justified, so lower resolutions drop low bits (sh)
  task automatic scan(input logic [15:0] cfg, input int w, input bit z,
    input int sh);
    wr(ADDR_CFG, cfg);
    panel_touched <= 1'b1;
    `WAIT_FOR(result_ready_n === 1'b0)
    `WAIT_FOR(x_drv_en === 1'b1)
    width = 0;
    while (x_drv_en === 1'b1 && width < 2000)
    begin
      @(posedge ref_clk);
      width++;
    end
    `CHK(width inside {[w - 2:w + 2]}, 1'b1)
    // Z1 phase, one store cycle with drivers off, then the Z2 conversion
    if (z)
      for (int i = 0; i < 2; i++)
      begin
        `WAIT_FOR(z_drv_en === 1'b1)
        `WAIT_FOR(z_drv_en === 1'b0)
      end
    repeat (3) @(posedge ref_clk);
    rd(ADDR_Y, {4'h0, VY >> sh});
    rd(ADDR_X, {4'h0, VX >> sh});
    if (z)
    begin
      rd(ADDR_Z1, {4'h0, VZ1 >> sh});
      rd(ADDR_Z2, {4'h0, VZ2 >> sh});
    end
    `CHK(result_ready_n, 1'b1)
    panel_touched <= 1'b0;
    repeat (4) @(posedge ref_clk);
    #1;
    `CHK(conv_clk_en, 1'b0)
  endtask

  task automatic end_sim();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Hang guard well past the expected run length
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    end_sim();
  end

  // Main sequence
  initial
  begin
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    for (int a = 0; a < 5; a++)
      rd(5'(a), RESULT_RST);
    rd(ADDR_DAC, 16'h0080);
    rd(ADDR_CTL, 16'h4000);
    rd(5'h1F, 16'h0000);
    wr(ADDR_DAC, 16'hFFA5);
    #1;
    `CHK(dac_code_bits, 8'hA5)
    rd(ADDR_DAC, 16'h00A5);
    @(posedge ref_clk);
    key_matrix <= 16'h2140;
    key_valid <= 1'b1;
    @(posedge ref_clk);
    key_valid <= 1'b0;
    repeat (2) @(posedge ref_clk);
    `CHK(result_ready_n, 1'b0)
    wr(ADDR_KEY, 16'hFFFF);
    rd(ADDR_KEY, 16'h2140);
    rd(ADDR_CTL, 16'h4000);
    scan(16'h0000, SET0 + OVH + CV0, 1'b0, 0);
    scan(16'h0004, SET0 + OVH + CV0, 1'b1, 0);
    // Settle, precharge and sense all one step up, averaging two
    scan(16'h2A88, SET1 + OVH + 2 * CV1, 1'b0, 0);
    // Eight-bit results on the slowest bit clock
    scan(16'h6AA8, SET1 + OVH + 2 * CV3, 1'b0, 4);
    // Host-controlled single Y conversion with the panel untouched
    wr(ADDR_CFG, 16'h0002);
    wr(ADDR_CTL, 16'h0003);
    `WAIT_FOR(result_ready_n === 1'b0)
    rd(ADDR_CTL, 16'h0002);
    rd(ADDR_Y, {4'h0, VY});
    wr(ADDR_CFG, 16'h0000);
    panel_touched <= 1'b1;
    repeat (10) @(posedge ref_clk);
    panel_touched <= 1'b0;
    repeat (600)
    begin
      @(posedge ref_clk);
      if (x_drv_en !== 1'b0)
        x_seen = 1'b1;
    end
    `CHK(x_seen, 1'b0)
    rd(ADDR_Y, {4'h0, VY});
    end_sim();
  end
endmodule

// ===== tb/tss_panel_model.sv
// Panel and converter model giving a level per driven axis
`timescale 1ns/1ps
module tss_panel_model
  import tss_pkg::*;
#(
  parameter logic [11:0] Y_VAL = 12'h5A3,
  parameter logic [11:0] X_VAL = 12'hA5C,
  parameter logic [11:0] Z1_VAL = 12'h3C1,
  parameter logic [11:0] Z2_VAL = 12'hC3E
)
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic adc_sample,
  input wire logic adc_power_on,
  input wire logic y_drv_en,
  input wire logic x_drv_en,
  input wire logic z_drv_en,
  output logic [ADC_BITS-1:0] adc_data
);
  logic [ADC_BITS-1:0] val_ff;
  logic z2_ff;
  logic z_prev_ff;
  // Level latched at sample start; only the first pressure value
  // settles, and the drivers drop for the store between the two
  // Two pressure values
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      val_ff <= '0;
      z2_ff <= 1'b0;
      z_prev_ff <= 1'b0;
    end
    else
    begin
      z_prev_ff <= z_drv_en;
      if (z_drv_en && !adc_power_on)
        z2_ff <= 1'b0;
      else if (z_prev_ff && !z_drv_en)
        z2_ff <= 1'b1;
      if (adc_sample)
        val_ff <= z_drv_en ? (z2_ff ? Z2_VAL : Z1_VAL)
          : (y_drv_en ? Y_VAL : (x_drv_en ? X_VAL : ~Y_VAL));
    end
  end
  // Inverted outside conversion so a mistimed capture shows up
  assign adc_data = adc_power_on ? val_ff : ~val_ff;
endmodule

// ===== tb/tss_scan_regs_properties.sv
// Port-level assertions for the touch scan sequencer
`timescale 1ns/1ps
module tss_scan_props
  import tss_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [4:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic panel_touched,
  input wire logic pen_touch_irq_n,
  input wire logic result_ready_n,
  input wire logic conv_clk_en,
  input wire logic adc_power_on,
  input wire logic adc_sample,
  input wire logic y_drv_en,
  input wire logic x_drv_en,
  input wire logic [DAC_BITS-1:0] dac_code_bits
);
  // One clock domain, all checks quiet in reset
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  property p_pen;
    1'b1 |=> pen_touch_irq_n == !$past(panel_touched);
  endproperty
  a_pen: assert property (p_pen) else $error("pen line wrong");
  property p_start;
    $fell(pen_touch_irq_n) |-> ##[0:1] (conv_clk_en && y_drv_en);
  endproperty
  a_start: assert property (p_start) else $error("no Y start");
  property p_xgo;
    $rose(x_drv_en) |-> !pen_touch_irq_n && conv_clk_en && !y_drv_en;
  endproperty
  a_xgo: assert property (p_xgo) else $error("X without touch");
  property p_smp;
    adc_sample |=> !adc_sample && adc_power_on;
  endproperty
  a_smp: assert property (p_smp) else $error("sample pulse bad");
  property p_dacwr;
    reg_wr && reg_addr == ADDR_DAC |=>
      dac_code_bits == DAC_BITS'($past(reg_wdata));
  endproperty
  a_dacwr: assert property (p_dacwr) else $error("dac code bad");
  property p_dacrd;
    reg_rd && !reg_wr && reg_addr == ADDR_DAC |=>
      reg_rdata == {8'h00, dac_code_bits};
  endproperty
  a_dacrd: assert property (p_dacrd) else $error("dac read bad");
  property p_upper;
    reg_rd && reg_addr <= ADDR_Z2 |=> reg_rdata[15:12] == 4'h0;
  endproperty
  a_upper: assert property (p_upper) else $error("upper bits set");
  property p_mirror;
    reg_rd && reg_addr == ADDR_CTL |=>
      reg_rdata[CTL_READY_BIT] == $past(result_ready_n);
  endproperty
  a_mirror: assert property (p_mirror) else $error("mirror bad");
endmodule
bind tss_scan_regs tss_scan_props u_props (
  .ref_clk(ref_clk),
  .reset_n(reset_n),
  .reg_addr(reg_addr),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata),
  .panel_touched(panel_touched),
  .pen_touch_irq_n(pen_touch_irq_n),
  .result_ready_n(result_ready_n),
  .conv_clk_en(conv_clk_en),
  .adc_power_on(adc_power_on),
  .adc_sample(adc_sample),
  .y_drv_en(y_drv_en),
  .x_drv_en(x_drv_en),
  .dac_code_bits(dac_code_bits)
);
